// File: inc/adcss_pkg.sv
// Constants and types of the repeat sweep converter controller.
// Assumes an AXI4-Lite master and an external analog converter core.
package adcss_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int unsigned AXI_ADDR_W  = 8;
   localparam int unsigned AXI_DATA_W  = 32;
   localparam int unsigned CHAN_W      = 5;
   localparam int unsigned CODE_W      = 10;
   localparam int unsigned RIDX_W      = 3;
   localparam int unsigned NUM_RESULTS = 8;
   localparam int unsigned CKS_W       = 3;
   localparam int unsigned REG_W       = 8;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_CTRL0  = 8'h00;
   localparam logic [7:0] OFS_CTRL1  = 8'h04;
   localparam logic [7:0] OFS_MODE   = 8'h08;
   localparam logic [7:0] OFS_INSEL  = 8'h0c;
   localparam logic [7:0] OFS_REFCR  = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [2:0] RES_PAGE   = 3'h1;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int unsigned START_POS  = 0;
   localparam int unsigned RES10_POS  = 0;
   localparam int unsigned TRIG_LSB   = 1;
   localparam int unsigned CKS_LSB    = 3;
   localparam int unsigned GRP_LSB    = 4;
   localparam int unsigned SWP_LSB    = 6;
   localparam int unsigned STAT_ST    = 0;
   localparam int unsigned STAT_IDX   = 2;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_MODE  = 8'h01;
   localparam logic [7:0] RST_INSEL = 8'h00;
   localparam logic [7:0] RST_REFCR = 8'h00;
   // ****************************************
   // Codes
   // ****************************************
   localparam logic [1:0] TRIG_SW    = 2'h0;
   localparam logic [1:0] TRIG_TMR_D = 2'h1;
   localparam logic [1:0] TRIG_TMR_C = 2'h2;
   localparam logic [1:0] TRIG_EXT   = 2'h3;
   localparam logic [1:0] GRP_AT0    = 2'h0;
   localparam logic [1:0] GRP_AT8    = 2'h1;
   localparam logic [4:0] PIN_BASE0  = 5'h00;
   localparam logic [4:0] PIN_BASE8  = 5'h08;
   localparam logic [4:0] PIN_BASE16 = 5'h10;
   localparam logic [9:0] CODE8_MASK = 10'h0ff;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ISSUE, ST_WAIT} adcss_state_type;
endpackage : adcss_pkg

// File: rtl/adcss_pair_buf.sv
// Two-entry valid/ready buffer.
// Assumes one clock and synchronous active-high reset.
module adcss_pair_buf #(
   parameter int unsigned W = 14
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] mem_ff [2];
   logic         wr_ptr_ff;
   logic         rd_ptr_ff;
   logic [1:0]   cnt_ff;
   logic [1:0]   nxt_cnt;
   logic         ready_ff;
   wire          push = in_valid & ready_ff;
   wire          pop  = out_valid & out_ready;

   assign in_ready  = ready_ff;
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data  = mem_ff[rd_ptr_ff];
   assign nxt_cnt   = cnt_ff + {1'b0, push} - {1'b0, pop};

   // Ready is registered so a full buffer really stalls the source
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
         ready_ff  <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            mem_ff[wr_ptr_ff] <= in_data;
            wr_ptr_ff         <= ~wr_ptr_ff;
         end
         if (pop)
            rd_ptr_ff <= ~rd_ptr_ff;
         cnt_ff   <= nxt_cnt;
         ready_ff <= (nxt_cnt != 2'h2);
      end
   end
endmodule : adcss_pair_buf

// File: rtl/adcss_sweep_top.sv
// Repeat sweep sequencer with AXI4-Lite registers and result store.
// Assumes a converter core that takes a start pulse and returns a code.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module adcss_sweep_top
   import adcss_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              rst,
   input  wire logic [adcss_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [adcss_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   output logic [1:0]                             s_axi_bresp,
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   input  wire logic [adcss_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   output logic [adcss_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                             s_axi_rresp,
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   input  wire logic                              trig_timer_d,
   input  wire logic                              trig_timer_c,
   input  wire logic                              trig_ext,
   output logic                                   conv_start,
   output logic [adcss_pkg::CHAN_W-1:0]           conv_channel,
   output logic                                   conv_res10,
   output logic [adcss_pkg::CKS_W-1:0]            conv_clk_sel,
   input  wire logic                              res_valid,
   input  wire logic [adcss_pkg::CODE_W-1:0]      res_code,
   output logic                                   res_ready,
   output logic                                   irq_group_done,
   output logic                                   busy
);
   import adcss_pkg::*;

   localparam int unsigned BUF_W = 1 + RIDX_W + CODE_W;

   // ****************************************
   // Bus slave state
   // ****************************************
   logic                  awready_ff;
   logic                  wready_ff;
   logic                  aw_held_ff;
   logic                  w_held_ff;
   logic [AXI_ADDR_W-1:0] awaddr_ff;
   logic [REG_W-1:0]      wbyte_ff;
   logic                  wbyte_en_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  arready_ff;
   logic                  rvalid_ff;
   logic [1:0]            rresp_ff;
   logic [AXI_DATA_W-1:0] rdata_ff;

   // ****************************************
   // Registers and sequencer state
   // ****************************************
   logic                  start_ff;
   logic [REG_W-1:0]      ctrl1_ff;
   logic [REG_W-1:0]      mode_ff;
   logic [REG_W-1:0]      insel_ff;
   logic [REG_W-1:0]      refcr_ff;
   logic [CODE_W-1:0]     result_ff [NUM_RESULTS];
   adcss_state_type       st_ff;
   adcss_state_type       nxt_st;
   logic [RIDX_W-1:0]     idx_ff;
   logic [RIDX_W-1:0]     nxt_idx;
   logic                  conv_start_ff;
   logic [CHAN_W-1:0]     conv_channel_ff;
   logic                  conv_res10_ff;
   logic                  irq_ff;
   logic                  busy_ff;

   // ****************************************
   // Decode
   // ****************************************
   wire aw_hs    = s_axi_awvalid & awready_ff;
   wire w_hs     = s_axi_wvalid & wready_ff;
   wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
   wire ar_hs    = s_axi_arvalid & arready_ff;
   wire wr_ctrl0 = do_write & (awaddr_ff == OFS_CTRL0);
   wire wr_ctrl1 = do_write & (awaddr_ff == OFS_CTRL1);
   wire wr_mode  = do_write & (awaddr_ff == OFS_MODE);
   wire wr_insel = do_write & (awaddr_ff == OFS_INSEL);
   wire wr_refcr = do_write & (awaddr_ff == OFS_REFCR);
   wire wr_hit   = (awaddr_ff == OFS_CTRL0) | (awaddr_ff == OFS_CTRL1) |
                   (awaddr_ff == OFS_MODE) | (awaddr_ff == OFS_INSEL) |
                   (awaddr_ff == OFS_REFCR) | (awaddr_ff == OFS_STATUS);
   wire rd_res   = (s_axi_araddr[7:5] == RES_PAGE) & (s_axi_araddr[1:0] == 2'h0);
   wire [RIDX_W-1:0] rd_ridx = s_axi_araddr[4:2];
   wire rd_known = rd_res | (s_axi_araddr == OFS_CTRL0) |
                   (s_axi_araddr == OFS_CTRL1) | (s_axi_araddr == OFS_MODE) |
                   (s_axi_araddr == OFS_INSEL) | (s_axi_araddr == OFS_REFCR) |
                   (s_axi_araddr == OFS_STATUS);
   wire [AXI_DATA_W-1:0] rd_status = (32'(idx_ff) << STAT_IDX) |
                                     (32'(st_ff) << STAT_ST);
   wire [AXI_DATA_W-1:0] rd_mux =
      rd_res                         ? 32'(result_ff[rd_ridx]) :
      (s_axi_araddr == OFS_CTRL0)    ? (32'(start_ff) << START_POS) :
      (s_axi_araddr == OFS_CTRL1)    ? 32'(ctrl1_ff) :
      (s_axi_araddr == OFS_MODE)     ? 32'(mode_ff) :
      (s_axi_araddr == OFS_INSEL)    ? 32'(insel_ff) :
      (s_axi_araddr == OFS_REFCR)    ? 32'(refcr_ff) :
      (s_axi_araddr == OFS_STATUS)   ? rd_status : 32'h0000_0000;

   // ****************************************
   // Configuration fields
   // ****************************************
   wire             res10_sel = mode_ff[RES10_POS];
   wire [1:0]       trig_src  = mode_ff[TRIG_LSB +: 2];
   wire [1:0]       grp_sel   = insel_ff[GRP_LSB +: 2];
   wire [1:0]       swp_sel   = insel_ff[SWP_LSB +: 2];
   // Six and eight pin groups cannot start at pin 16
   wire [CHAN_W-1:0] group_base = (grp_sel == GRP_AT0) ? PIN_BASE0 :
                                  ((grp_sel == GRP_AT8) | swp_sel[1]) ?
                                  PIN_BASE8 : PIN_BASE16;
   wire [RIDX_W-1:0] pass_last = {swp_sel, 1'b1};
   wire idx_last  = (idx_ff == pass_last);
   wire trig_hit  = ((trig_src == TRIG_TMR_D) & trig_timer_d) |
                    ((trig_src == TRIG_TMR_C) & trig_timer_c) |
                    ((trig_src == TRIG_EXT) & trig_ext);

   // ****************************************
   // Result path
   // ****************************************
   logic              buf_in_ready;
   logic              buf_out_valid;
   logic [BUF_W-1:0]  buf_out_data;
   wire res_accept  = res_valid & buf_in_ready;
   wire [CODE_W-1:0] code_kept = conv_res10_ff ? res_code :
                                 (res_code & CODE8_MASK);
   // Low channel bits name the result slot because bases are multiples of 8
   wire [BUF_W-1:0] buf_in_data = {idx_last, conv_channel_ff[RIDX_W-1:0],
                                   code_kept};
   // Drain stalls on a result read so both never touch the store at once
   wire buf_out_ready = ~(ar_hs & rd_res);
   wire drain_fire    = buf_out_valid & buf_out_ready;
   wire drain_last    = buf_out_data[BUF_W-1];
   wire [RIDX_W-1:0] drain_idx  = buf_out_data[CODE_W +: RIDX_W];
   wire [CODE_W-1:0] drain_code = buf_out_data[CODE_W-1:0];
   wire running = start_ff & (st_ff != ST_IDLE);

   adcss_pair_buf #(
      .W         (BUF_W)
   ) u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (res_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data)
   );

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb
   begin
      nxt_st  = st_ff;
      nxt_idx = idx_ff;
      if (!start_ff)
      begin
         nxt_st  = ST_IDLE;
         nxt_idx = '0;
      end
      else
      begin
         unique case (st_ff)
            ST_IDLE:
               nxt_st = (trig_src == TRIG_SW) ? ST_ISSUE : ST_ARMED;
            ST_ARMED:
               if (trig_hit)
                  nxt_st = ST_ISSUE;
            ST_ISSUE:
               nxt_st = ST_WAIT;
            ST_WAIT:
               if (res_accept)
               begin
                  nxt_st  = ST_ISSUE;
                  nxt_idx = idx_last ? '0 : idx_ff + 3'h1;
               end
         endcase
      end
   end

   // Triggers only matter in the armed state, so a running sweep ignores them
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_ff           <= ST_IDLE;
         idx_ff          <= '0;
         conv_start_ff   <= 1'b0;
         conv_channel_ff <= '0;
         conv_res10_ff   <= 1'b0;
         busy_ff         <= 1'b0;
         irq_ff          <= 1'b0;
      end
      else
      begin
         st_ff           <= nxt_st;
         idx_ff          <= nxt_idx;
         conv_start_ff   <= (nxt_st == ST_ISSUE);
         conv_channel_ff <= group_base + CHAN_W'(nxt_idx);
         conv_res10_ff   <= res10_sel;
         busy_ff         <= (nxt_st == ST_ISSUE) | (nxt_st == ST_WAIT);
         irq_ff          <= drain_fire & drain_last & running;
      end
   end

   // Every pass overwrites, no read handshake needed
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_RESULTS; i++)
            result_ff[i] <= '0;
      end
      else if (drain_fire)
         result_ff[drain_idx] <= drain_code;
   end

   // ****************************************
   // Register writes
   // ****************************************
   // Config writes are honoured at any time; stopping first is up to software
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         start_ff <= 1'b0;
         ctrl1_ff <= RST_CTRL1;
         mode_ff  <= RST_MODE;
         insel_ff <= RST_INSEL;
         refcr_ff <= RST_REFCR;
      end
      else if (wbyte_en_ff)
      begin
         if (wr_ctrl0)
            start_ff <= wbyte_ff[START_POS];
         if (wr_ctrl1)
            ctrl1_ff <= wbyte_ff;
         if (wr_mode)
            mode_ff <= wbyte_ff;
         if (wr_insel)
            insel_ff <= wbyte_ff;
         if (wr_refcr)
            refcr_ff <= wbyte_ff;
      end
   end

   // ****************************************
   // AXI4-Lite handshakes
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         awready_ff  <= 1'b1;
         wready_ff   <= 1'b1;
         aw_held_ff  <= 1'b0;
         w_held_ff   <= 1'b0;
         awaddr_ff   <= '0;
         wbyte_ff    <= '0;
         wbyte_en_ff <= 1'b0;
         bvalid_ff   <= 1'b0;
         bresp_ff    <= RESP_OKAY;
      end
      else
      begin
         if (aw_hs)
         begin
            awaddr_ff  <= s_axi_awaddr;
            aw_held_ff <= 1'b1;
            awready_ff <= 1'b0;
         end
         if (w_hs)
         begin
            wbyte_ff    <= s_axi_wdata[REG_W-1:0];
            wbyte_en_ff <= s_axi_wstrb[0];
            w_held_ff   <= 1'b1;
            wready_ff   <= 1'b0;
         end
         if (do_write)
         begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_ff & s_axi_bready)
         begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= RESP_OKAY;
         rdata_ff   <= '0;
      end
      else if (ar_hs)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rd_mux;
         rresp_ff   <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff & s_axi_rready)
      begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   assign s_axi_awready  = awready_ff;
   assign s_axi_wready   = wready_ff;
   assign s_axi_bvalid   = bvalid_ff;
   assign s_axi_bresp    = bresp_ff;
   assign s_axi_arready  = arready_ff;
   assign s_axi_rvalid   = rvalid_ff;
   assign s_axi_rresp    = rresp_ff;
   assign s_axi_rdata    = rdata_ff;
   assign conv_start     = conv_start_ff;
   assign conv_channel   = conv_channel_ff;
   assign conv_res10     = conv_res10_ff;
   assign conv_clk_sel   = mode_ff[CKS_LSB +: CKS_W];
   assign res_ready      = buf_in_ready;
   assign irq_group_done = irq_ff;
   assign busy           = busy_ff;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   wire [CHAN_W-1:0] group_top = group_base + CHAN_W'(pass_last);

   sequence s_step;
      st_ff == ST_WAIT && res_accept && !idx_last && start_ff;
   endsequence
   sequence s_wrap;
      st_ff == ST_WAIT && res_accept && idx_last && start_ff;
   endsequence

   property p_stop_idle;
      !start_ff |=> st_ff == ST_IDLE && !conv_start_ff;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("sweep kept running after stop");

   property p_no_self_stop;
      running && !wr_ctrl0 |=> st_ff != ST_IDLE;
   endproperty
   a_no_self_stop: assert property (p_no_self_stop)
      else $error("sweep stopped on its own");

   property p_irq_cause;
      irq_ff |-> $past(drain_fire && drain_last && start_ff);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("group request without completed pass");

   property p_irq_abort;
      !start_ff |=> !irq_ff;
   endproperty
   a_irq_abort: assert property (p_irq_abort)
      else $error("request after software stop");

   property p_in_group;
      conv_start_ff |-> conv_channel_ff >= group_base && conv_channel_ff <= group_top;
   endproperty
   a_in_group: assert property (p_in_group)
      else $error("channel outside selected group");

   property p_ascend;
      s_step |=> conv_start_ff && conv_channel_ff == $past(conv_channel_ff) + 5'h01;
   endproperty
   a_ascend: assert property (p_ascend)
      else $error("channel not next in order");

   property p_wrap;
      s_wrap |=> conv_start_ff && conv_channel_ff == group_base;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("pass did not restart at lowest pin");

   property p_trig_start;
      st_ff == ST_ARMED && start_ff && trig_hit |=> conv_start_ff ##1 st_ff == ST_WAIT;
   endproperty
   a_trig_start: assert property (p_trig_start)
      else $error("trigger did not start sweep");

   property p_trig_ignored;
      st_ff == ST_WAIT && start_ff && !res_accept |=> st_ff == ST_WAIT;
   endproperty
   a_trig_ignored: assert property (p_trig_ignored)
      else $error("trigger disturbed running sweep");

   property p_store;
      drain_fire |=> result_ff[$past(drain_idx)] == $past(drain_code);
   endproperty
   a_store: assert property (p_store)
      else $error("result not stored");

   property p_res8;
      res_accept && !conv_res10_ff |-> buf_in_data[CODE_W-1:8] == 2'h0;
   endproperty
   a_res8: assert property (p_res8)
      else $error("eight-bit code too wide");
endmodule : adcss_sweep_top

// File: verification/adcss_conv_model.sv
// Behavioural converter core on the far side of the sequencer.
// Assumes one conv_start per conversion and holds each code until taken.
module adcss_conv_model
   import adcss_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire logic                         conv_start,
   input  wire logic [adcss_pkg::CHAN_W-1:0] conv_channel,
   input  wire logic                         res_ready,
   input  wire logic [2:0]                   slow,
   input  wire logic [9:0]                   salt,
   output logic                              res_valid,
   output logic [adcss_pkg::CODE_W-1:0]      res_code
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] wait_ff;
   logic [4:0] ch_ff;
   logic       busy_ff;
   logic       valid_ff;
   wire logic [9:0] code = 10'(ch_ff * 45) ^ salt;
   // Idle code is inverted so a stale value never matches
   assign res_code  = valid_ff ? code : ~code;
   assign res_valid = valid_ff;
   // One steady clock; no sleep, clock switch or flash stop is modelled
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy_ff  <= 1'b0;
         valid_ff <= 1'b0;
      end
      else if (conv_start)
      begin
         busy_ff <= 1'b1;
         ch_ff   <= conv_channel;
         wait_ff <= slow;
      end
      else if (busy_ff && wait_ff != 3'h0) wait_ff <= wait_ff - 3'h1;
      else if (busy_ff && !valid_ff) valid_ff <= 1'b1;
      else if (valid_ff && res_ready)
      begin
         valid_ff <= 1'b0;
         busy_ff  <= 1'b0;
      end
   end
endmodule : adcss_conv_model

// File: verification/test_adc_sweep_sequencer.sv
// Self-checking bench of the repeat sweep sequencer.
// Assumes the converter model and the design package.
module test_adc_sweep_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   import adcss_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic        clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, trig_timer_d = 0, trig_timer_c = 0;
   logic        trig_ext = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, conv_start, conv_res10, res_valid, res_ready;
   logic        irq_group_done, busy;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [4:0]  conv_channel;
   logic [2:0]  conv_clk_sel, slow = 0;
   logic [9:0]  res_code, salt = 0;
   int          fails = 0, n_tests = 0, cyc = 0, irq_n = 0, st_n = 0, seed = 32'hc685574f;
   int          exp_q[$];
   adcss_sweep_top adcss_sweep_top_inst (
      .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .trig_timer_d(trig_timer_d), .trig_timer_c(trig_timer_c), .trig_ext(trig_ext),
      .conv_start(conv_start), .conv_channel(conv_channel), .conv_res10(conv_res10),
      .conv_clk_sel(conv_clk_sel), .res_valid(res_valid), .res_code(res_code),
      .res_ready(res_ready), .irq_group_done(irq_group_done), .busy(busy));
   adcss_conv_model adcss_conv_model_inst (
      .clk(clk), .rst(rst), .conv_start(conv_start), .conv_channel(conv_channel),
      .res_ready(res_ready), .slow(slow), .salt(salt), .res_valid(res_valid),
      .res_code(res_code));
   always #12.5 clk = ~clk;
   // ****************************************
   // Tasks
   // ****************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
      cmp(s_axi_bresp, er);
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 0;
      cmp(s_axi_rresp, er);
      cmp(s_axi_rdata, ed);
   endtask : axr
   task automatic run(input int t);
      int sw, gp, tg, n, base, k, ch, s, s2;
      sw = t % 4;
      gp = t % 3;
      tg = t % 4;
      n = 2 * (sw + 1);
      base = (gp == 2 && sw > 1) ? 8 : 8 * gp;
      salt <= 10'($random(seed));
      slow <= 3'($random(seed));
      axw(OFS_MODE, (t / 2) % 2 | tg << 1 | (t % 8) << 3, RESP_OKAY);
      axw(OFS_INSEL, sw << 6 | gp << 4, RESP_OKAY);
      cmp(conv_res10, (t / 2) % 2);
      cmp(conv_clk_sel, t % 8);
      for (k = 0; k < 6 * n; k++) exp_q.push_back(base + k % n);
      s = irq_n;
      s2 = st_n;
      axw(OFS_CTRL0, 1, RESP_OKAY);
      if (tg != 0)
      begin
         repeat (4) @(posedge clk);
         cmp(busy, 0);
         axr(OFS_STATUS, 1, RESP_OKAY);
         // Trigger stays high through the sweep, which must ignore it
         {trig_timer_d, trig_timer_c, trig_ext} <= 3'(1 << (3 - tg));
      end
      while (irq_n < s + 2) @(posedge clk);
      cmp(st_n - s2 - 2 * n <= 1 && st_n - s2 >= 2 * n, 1);
      {trig_timer_d, trig_timer_c, trig_ext} <= 3'h0;
      // Results are read while running; a stop does not clear them, the store keeps its last codes
      for (k = 0; k < n; k++)
      begin
         ch = base + k;
         s = ((ch * 45) ^ salt) & ((t / 2) % 2 ? 10'h3ff : 10'h0ff);
         axr({RES_PAGE, 3'(ch % 8), 2'h0}, s, RESP_OKAY);
      end
      axw(OFS_CTRL0, 0, RESP_OKAY);
      s = irq_n;
      repeat (40) @(posedge clk);
      cmp(irq_n, s);
      cmp(busy, 0);
      exp_q.delete();
   endtask : run
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test
   // ****************************************
   // Monitor and sequence
   // ****************************************
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      irq_n <= irq_n + (irq_group_done === 1'b1);
      st_n <= st_n + (conv_start === 1'b1);
      if (conv_start === 1'b1 && exp_q.size() > 0) cmp(conv_channel, exp_q.pop_front());
      if (cyc > 40000)
      begin
         fails++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 0;
      axr(OFS_MODE, RST_MODE, RESP_OKAY);
      axr(OFS_STATUS, 0, RESP_OKAY);
      cmp(res_ready, 1);
      axr(8'h18, 0, RESP_SLVERR);
      axw(8'h18, 1, RESP_SLVERR);
      for (int t = 0; t < 12; t++) run(t);
      end_of_test();
   end
endmodule : test_adc_sweep_sequencer
